// *** logic/afrc_pkg.sv ***
package afrc_pkg;
	// register byte offsets on the control port
	localparam logic [7:0] OFS_CHAN_FAULT = 8'h70;
	localparam logic [7:0] OFS_GLOBAL1 = 8'h71;
	localparam logic [7:0] OFS_GLOBAL2 = 8'h72;
	localparam logic [7:0] OFS_OTW_STATUS = 8'h73;
	localparam logic [7:0] OFS_REPORT_MASK = 8'h74;
	localparam logic [7:0] OFS_LATCH_CTRL = 8'h75;
	localparam logic [7:0] OFS_MISC_CTRL = 8'h76;
	localparam logic [7:0] OFS_FAULT_CLEAR = 8'h78;
	// reset values
	localparam logic [7:0] RST_REPORT_MASK = 8'h00;
	localparam logic [7:0] RST_LATCH_CTRL = 8'hf8;
	localparam logic [7:0] RST_MISC_CTRL = 8'h00;
	localparam logic [6:0] RST_CLEAR_RSVD = 7'h00;
	// report mask bit positions
	localparam int B_SHUTDOWN_REPORT_MASK = 7;
	localparam int B_MASK_LS_UV = 6;
	localparam int B_MASK_LS_OV = 5;
	localparam int B_MASK_CLK = 4;
	localparam int B_MASK_PS_UV = 3;
	localparam int B_MASK_PS_OV = 2;
	localparam int B_DC_FAULT_REPORT_MASK = 1;
	localparam int B_OVERCURRENT_REPORT_MASK = 0;
	// latch control bit positions
	localparam int B_CLK_LATCH_EN = 5;
	localparam int B_SHUTDOWN_LATCH_ENABLE = 4;
	localparam int B_WARNING_LATCH_ENABLE = 3;
	localparam int B_WARNING_REPORT_MASK = 2;
	// misc control bit positions
	localparam int B_CLK_DET_HOLD = 7;
	localparam int B_AUTO_REC = 4;
	// status and fault clear command bit positions
	localparam int B_OTW_FLAG = 2;
	localparam int B_CLEAR_CMD = 7;
	// fault vector index
	localparam int NFLT = 11;
	localparam int F_DC_L = 0;
	localparam int F_DC_R = 1;
	localparam int F_OC_L = 2;
	localparam int F_OC_R = 3;
	localparam int F_CLK = 4;
	localparam int F_PS_OV = 5;
	localparam int F_PS_UV = 6;
	localparam int F_OVERTEMP_SHUTDOWN = 7;
	localparam int F_OTW = 8;
	localparam int F_LS_OV = 9;
	localparam int F_LS_UV = 10;
endpackage

// *** logic/afrc_ctl_if.sv ***
`timescale 1ns/1ps
interface afrc_ctl_if;
	logic [7:0] report_mask;
	logic [7:0] latch_ctrl;
	logic [7:0] misc_ctrl;
	logic clear;
	logic [afrc_pkg::NFLT-1:0] raw;
	logic [afrc_pkg::NFLT-1:0] flags;
	logic fault_report;
	modport regs (
		output report_mask,
		output latch_ctrl,
		output misc_ctrl,
		output clear,
		input flags
	);
	modport core (
		input report_mask,
		input latch_ctrl,
		input misc_ctrl,
		input clear,
		input raw,
		output flags,
		output fault_report
	);
endinterface

// *** logic/afrc_fault_core.sv ***
`timescale 1ns/1ps
module afrc_fault_core (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	afrc_ctl_if.core ctl
);
	logic [afrc_pkg::NFLT-1:0] flags_q;
	logic [afrc_pkg::NFLT-1:0] flags_d;
	logic [afrc_pkg::NFLT-1:0] latch_en;
	logic [afrc_pkg::NFLT-1:0] rpt_en;
	logic report_q;
	logic report_d;

	// which faults stick and which reach the report pin
	always_comb
	begin
		latch_en = '1;
		latch_en[afrc_pkg::F_CLK] =
			ctl.latch_ctrl[afrc_pkg::B_CLK_LATCH_EN];
		latch_en[afrc_pkg::F_OVERTEMP_SHUTDOWN] =
			ctl.latch_ctrl[afrc_pkg::B_SHUTDOWN_LATCH_ENABLE]
			& ~ctl.misc_ctrl[afrc_pkg::B_AUTO_REC];
		latch_en[afrc_pkg::F_OTW] =
			ctl.latch_ctrl[afrc_pkg::B_WARNING_LATCH_ENABLE];
		// clock detect status follows live unless held or latch control bit 5 is set
		latch_en[afrc_pkg::F_CLK] = latch_en[afrc_pkg::F_CLK]
			| ctl.misc_ctrl[afrc_pkg::B_CLK_DET_HOLD];
		// supply faults track the supply, never stick
		latch_en[afrc_pkg::F_LS_OV] = 1'b0;
		latch_en[afrc_pkg::F_LS_UV] = 1'b0;
		latch_en[afrc_pkg::F_PS_OV] = 1'b0;
		latch_en[afrc_pkg::F_PS_UV] = 1'b0;
		rpt_en = '1;
		rpt_en[afrc_pkg::F_OVERTEMP_SHUTDOWN] =
			~ctl.report_mask[afrc_pkg::B_SHUTDOWN_REPORT_MASK];
		rpt_en[afrc_pkg::F_LS_UV] =
			~ctl.report_mask[afrc_pkg::B_MASK_LS_UV];
		rpt_en[afrc_pkg::F_LS_OV] =
			~ctl.report_mask[afrc_pkg::B_MASK_LS_OV];
		rpt_en[afrc_pkg::F_CLK] =
			~ctl.report_mask[afrc_pkg::B_MASK_CLK];
		rpt_en[afrc_pkg::F_PS_UV] =
			~ctl.report_mask[afrc_pkg::B_MASK_PS_UV];
		rpt_en[afrc_pkg::F_PS_OV] =
			~ctl.report_mask[afrc_pkg::B_MASK_PS_OV];
		rpt_en[afrc_pkg::F_DC_L] =
			~ctl.report_mask[afrc_pkg::B_DC_FAULT_REPORT_MASK];
		rpt_en[afrc_pkg::F_DC_R] =
			~ctl.report_mask[afrc_pkg::B_DC_FAULT_REPORT_MASK];
		rpt_en[afrc_pkg::F_OC_L] =
			~ctl.report_mask[afrc_pkg::B_OVERCURRENT_REPORT_MASK];
		rpt_en[afrc_pkg::F_OC_R] =
			~ctl.report_mask[afrc_pkg::B_OVERCURRENT_REPORT_MASK];
		rpt_en[afrc_pkg::F_OTW] =
			~ctl.latch_ctrl[afrc_pkg::B_WARNING_REPORT_MASK];
	end

	// live cause sets; held bit kept until clear; set beats clear
	always_comb
	begin
		flags_d = ctl.raw
			| (flags_q & latch_en & {afrc_pkg::NFLT{~ctl.clear}});
		// masked faults are still recorded, only the report drops
		report_d = |(flags_d & rpt_en);
	end

	// registers only
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			flags_q <= '0;
			report_q <= 1'b0;
		end
		else if (i_ce)
		begin
			flags_q <= flags_d;
			report_q <= report_d;
		end
	end

	assign ctl.flags = flags_q;
	assign ctl.fault_report = report_q;
endmodule // afrc_fault_core

// *** logic/afrc_regs.sv ***
`timescale 1ns/1ps
module afrc_regs (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	afrc_ctl_if.regs ctl
);
	logic [7:0] mask_q;
	logic [7:0] mask_d;
	logic [7:0] latch_q;
	logic [7:0] latch_d;
	logic [7:0] misc_q;
	logic [7:0] misc_d;
	logic [6:0] clr_rsvd_q;
	logic [6:0] clr_rsvd_d;
	logic clear_q;
	logic clear_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [10:0] f;

	assign f = ctl.flags;

	// write decode and read mux
	always_comb
	begin
		mask_d = mask_q;
		latch_d = latch_q;
		misc_d = misc_q;
		clr_rsvd_d = clr_rsvd_q;
		clear_d = 1'b0;
		rdata_d = rdata_q;
		if (i_wr)
		begin
			unique case (i_addr)
				afrc_pkg::OFS_REPORT_MASK: mask_d = i_wdata;
				// reserved fields hold what is written
				afrc_pkg::OFS_LATCH_CTRL: latch_d = i_wdata;
				afrc_pkg::OFS_MISC_CTRL: misc_d = i_wdata;
				afrc_pkg::OFS_FAULT_CLEAR:
				begin
					clr_rsvd_d = i_wdata[6:0];
					clear_d = i_wdata[afrc_pkg::B_CLEAR_CMD];
				end
				default: clear_d = 1'b0;
			endcase
		end
		if (i_rd)
		begin
			unique case (i_addr)
				afrc_pkg::OFS_CHAN_FAULT: rdata_d = {4'h0,
					f[afrc_pkg::F_DC_L], f[afrc_pkg::F_DC_R],
					f[afrc_pkg::F_OC_L], f[afrc_pkg::F_OC_R]};
				afrc_pkg::OFS_GLOBAL1: rdata_d = {5'h00,
					f[afrc_pkg::F_CLK], f[afrc_pkg::F_PS_OV],
					f[afrc_pkg::F_PS_UV]};
				afrc_pkg::OFS_GLOBAL2:
					rdata_d = {7'h00, f[afrc_pkg::F_OVERTEMP_SHUTDOWN]};
				afrc_pkg::OFS_OTW_STATUS:
					rdata_d = {5'h00, f[afrc_pkg::F_OTW], 2'h0};
				afrc_pkg::OFS_REPORT_MASK: rdata_d = mask_q;
				afrc_pkg::OFS_LATCH_CTRL: rdata_d = latch_q;
				afrc_pkg::OFS_MISC_CTRL: rdata_d = misc_q;
				// command bit is write-only, reads zero
				afrc_pkg::OFS_FAULT_CLEAR: rdata_d = {1'b0, clr_rsvd_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			mask_q <= afrc_pkg::RST_REPORT_MASK;
			latch_q <= afrc_pkg::RST_LATCH_CTRL;
			misc_q <= afrc_pkg::RST_MISC_CTRL;
			clr_rsvd_q <= afrc_pkg::RST_CLEAR_RSVD;
			clear_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else if (i_ce)
		begin
			mask_q <= mask_d;
			latch_q <= latch_d;
			misc_q <= misc_d;
			clr_rsvd_q <= clr_rsvd_d;
			clear_q <= clear_d;
			rdata_q <= rdata_d;
		end
	end

	assign ctl.report_mask = mask_q;
	assign ctl.latch_ctrl = latch_q;
	assign ctl.misc_ctrl = misc_q;
	assign ctl.clear = clear_q;
	assign o_rdata = rdata_q;
endmodule // afrc_regs

// *** logic/afrc_top.sv ***
// Behaviour
// - overtemp warning flag reads in bit 2 of its status register, rest zero.
// - mask bit 7 hides overtemp shutdown from the fault report.
// - mask bit 6 hides logic supply undervoltage from the report.
// - mask bit 5 hides logic supply overvoltage from the report.
// - mask bit 4 hides clock fault from the report.
// - mask bit 3 hides power stage undervoltage from the report.
// - mask bit 2 hides power stage overvoltage from the report.
// - mask bit 1 hides output dc faults from the report.
// - mask bit 0 hides output overcurrent faults from the report.
// - latch control bit 5 makes clock fault sticky; resets one.
// - latch control bit 4 makes overtemp shutdown sticky unless misc bit 4 is set; resets one.
// - latch control bit 3 makes overtemp warning sticky; resets one.
// - latch control bit 2 hides overtemp warning from the report.
// - latch control reserved bits reset to 11 and 00, writable.
// - misc bit 7 holds clock detect status; with it and latch control bit 5 both clear it follows live.
// - misc bit 4 lets overtemp shutdown recover by itself.
// - writing one to clear bit 7 clears latched faults.
// - per-channel dc and overcurrent flags readable at channel status.
// - overtemp shutdown flag readable in bit 0 of global status two.
`timescale 1ns/1ps
module afrc_top (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_dc_left,
	input wire logic i_dc_right,
	input wire logic i_oc_left,
	input wire logic i_oc_right,
	input wire logic i_clock_fault,
	input wire logic i_power_supply_ov,
	input wire logic i_power_supply_uv,
	input wire logic i_overtemp_shutdown,
	input wire logic i_overtemp_warning,
	input wire logic i_logic_supply_ov,
	input wire logic i_logic_supply_uv,
	output logic o_fault_report,
	output logic o_overtemp_shutdown
);
	afrc_ctl_if ctl ();

	// analog detectors are taken as synchronous levels
	assign ctl.raw = {i_logic_supply_uv, i_logic_supply_ov,
		i_overtemp_warning, i_overtemp_shutdown, i_power_supply_uv,
		i_power_supply_ov, i_clock_fault, i_oc_right, i_oc_left,
		i_dc_right, i_dc_left};

	afrc_regs u_regs (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.o_rdata(o_rdata),
		.ctl(ctl)
	);

	afrc_fault_core u_core (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.ctl(ctl)
	);

	// shutdown holds the power stage off while its flag stands
	assign o_overtemp_shutdown = ctl.flags[afrc_pkg::F_OVERTEMP_SHUTDOWN];
	assign o_fault_report = ctl.fault_report;
endmodule // afrc_top

// *** bench/afrc_top_chk.sv ***
`timescale 1ns/1ps
module afrc_top_chk (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic i_overtemp_shutdown,
	input wire logic o_overtemp_shutdown
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	a_overtemp_shutdown_set:
		assert property (i_ce && i_overtemp_shutdown |=> o_overtemp_shutdown)
		else $error("shutdown flag missed");
	a_overtemp_shutdown_read:
		assert property (i_ce && i_rd && i_addr == 8'h72
			|=> o_rdata == {7'h00, $past(o_overtemp_shutdown)})
		else $error("shutdown status read wrong");
	a_warn_read:
		assert property (i_ce && i_rd && i_addr == 8'h73
			|=> o_rdata[7:3] == 5'h00 && o_rdata[1:0] == 2'h0)
		else $error("warning status spare bits set");
	a_chan_spare:
		assert property (i_ce && i_rd && i_addr == 8'h70
			|=> o_rdata[7:4] == 4'h0)
		else $error("channel status spare bits set");
	a_clear_drops:
		assert property (i_ce && i_wr && i_addr == 8'h78 && i_wdata[7]
			&& !i_overtemp_shutdown ##1 !i_overtemp_shutdown
			|=> !o_overtemp_shutdown)
		else $error("clear left shutdown flag");
	a_clear_wo:
		assert property (i_ce && i_rd && i_addr == 8'h78 |=> !o_rdata[7])
		else $error("clear bit read back");
	// readbacks assume one idle cycle between write and read
	a_mask_rdbk:
		assert property (i_ce && i_wr && i_addr == 8'h74 ##1 !i_wr
			##1 i_rd && i_addr == 8'h74 |=> o_rdata == $past(i_wdata, 3))
		else $error("mask readback wrong");
	a_latch_rdbk:
		assert property (i_ce && i_wr && i_addr == 8'h75 ##1 !i_wr
			##1 i_rd && i_addr == 8'h75 |=> o_rdata == $past(i_wdata, 3))
		else $error("latch control readback wrong");
	a_misc_rdbk:
		assert property (i_ce && i_wr && i_addr == 8'h76 ##1 !i_wr
			##1 i_rd && i_addr == 8'h76 |=> o_rdata == $past(i_wdata, 3))
		else $error("misc control readback wrong");
endmodule // afrc_top_chk

bind afrc_top afrc_top_chk u_chk (.i_mclk, .i_rst_b, .i_ce, .i_wr, .i_rd,
	.i_addr, .i_wdata, .o_rdata, .i_overtemp_shutdown, .o_overtemp_shutdown);

// *** bench/test_afrc_top.sv ***
`timescale 1ns/1ps
module test_afrc_top;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_ce = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic [10:0] flt = 11'h000;
	logic [7:0] o_rdata;
	logic o_fault_report;
	logic o_overtemp_shutdown;
	int miscompares = 0;
	int n_tests = 0;
	// address, write data, read back; ends with latches off, no masks
	logic [7:0] rb [9][3] = '{'{8'h74, 8'hff, 8'hff}, '{8'h75, 8'h03, 8'h03},
		'{8'h76, 8'h90, 8'h90}, '{8'h78, 8'hff, 8'h7f},
		'{8'h74, 8'h00, 8'h00}, '{8'h76, 8'h00, 8'h00},
		'{8'h70, 8'hff, 8'h00}, '{8'h73, 8'hff, 8'h00},
		'{8'h77, 8'hff, 8'h00}};
	// mask address, masked value, unmasked value
	logic [7:0] mk [9][3] = '{'{8'h74, 8'h80, 8'h00}, '{8'h74, 8'h40, 8'h00},
		'{8'h74, 8'h20, 8'h00}, '{8'h74, 8'h10, 8'h00},
		'{8'h74, 8'h08, 8'h00}, '{8'h74, 8'h04, 8'h00},
		'{8'h74, 8'h02, 8'h00}, '{8'h74, 8'h01, 8'h00},
		'{8'h75, 8'h07, 8'h03}};
	int mf [9] = '{afrc_pkg::F_OVERTEMP_SHUTDOWN, afrc_pkg::F_LS_UV, afrc_pkg::F_LS_OV,
		afrc_pkg::F_CLK, afrc_pkg::F_PS_UV, afrc_pkg::F_PS_OV,
		afrc_pkg::F_DC_L, afrc_pkg::F_OC_R, afrc_pkg::F_OTW};
	// status address, status while masked; supply faults of logic have none
	logic [7:0] ms [9][2] = '{'{8'h72, 8'h01}, '{8'h71, 8'h00},
		'{8'h71, 8'h00}, '{8'h71, 8'h04}, '{8'h71, 8'h01},
		'{8'h71, 8'h02}, '{8'h70, 8'h08}, '{8'h70, 8'h01},
		'{8'h73, 8'h04}};
	// latch control, misc control, status address, status after pulse
	logic [7:0] lt [10][4] = '{'{8'hf8, 8'h00, 8'h72, 8'h01},
		'{8'he8, 8'h00, 8'h72, 8'h00}, '{8'hf8, 8'h10, 8'h72, 8'h00},
		'{8'hf8, 8'h00, 8'h71, 8'h04}, '{8'hd8, 8'h00, 8'h71, 8'h00},
		'{8'hd8, 8'h80, 8'h71, 8'h04}, '{8'hf8, 8'h00, 8'h73, 8'h04},
		'{8'hf0, 8'h00, 8'h73, 8'h00}, '{8'hf8, 8'h00, 8'h70, 8'h04},
		'{8'hf8, 8'h00, 8'h70, 8'h02}};
	int lf [10] = '{afrc_pkg::F_OVERTEMP_SHUTDOWN, afrc_pkg::F_OVERTEMP_SHUTDOWN, afrc_pkg::F_OVERTEMP_SHUTDOWN,
		afrc_pkg::F_CLK, afrc_pkg::F_CLK, afrc_pkg::F_CLK, afrc_pkg::F_OTW,
		afrc_pkg::F_OTW, afrc_pkg::F_DC_R, afrc_pkg::F_OC_L};

	always #20 i_mclk = ~i_mclk;

	// clock enable driven so a frozen write can be shown to drop
	afrc_top u_dut (.i_mclk, .i_rst_b, .i_ce, .i_wr, .i_rd, .i_addr,
		.i_wdata, .o_rdata, .i_dc_left(flt[afrc_pkg::F_DC_L]),
		.i_dc_right(flt[afrc_pkg::F_DC_R]), .i_oc_left(flt[afrc_pkg::F_OC_L]),
		.i_oc_right(flt[afrc_pkg::F_OC_R]), .i_clock_fault(flt[afrc_pkg::F_CLK]),
		.i_power_supply_ov(flt[afrc_pkg::F_PS_OV]),
		.i_power_supply_uv(flt[afrc_pkg::F_PS_UV]),
		.i_overtemp_shutdown(flt[afrc_pkg::F_OVERTEMP_SHUTDOWN]),
		.i_overtemp_warning(flt[afrc_pkg::F_OTW]),
		.i_logic_supply_ov(flt[afrc_pkg::F_LS_OV]),
		.i_logic_supply_uv(flt[afrc_pkg::F_LS_UV]), .o_fault_report,
		.o_overtemp_shutdown);

	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string nm);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	// idle cycle after each write keeps strobes from doubling up
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		chk(o_rdata, e, "rdata");
		@(posedge i_mclk);
	endtask

	task automatic rep(input logic e, input int n);
		repeat (n) @(posedge i_mclk);
		@(negedge i_mclk);
		chk({7'h00, o_fault_report}, {7'h00, e}, "fault_report");
		@(posedge i_mclk);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// main sequence: reset values, readback, masks, latches
	initial
	begin
		repeat (8) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		rd(8'h74, 8'h00);
		rd(8'h75, 8'hf8);
		rd(8'h76, 8'h00);
		rd(8'h73, 8'h00);
		// write while frozen must leave the mask at its reset value
		i_ce <= 1'b0;
		wr(8'h74, 8'hff);
		i_ce <= 1'b1;
		rd(8'h74, 8'h00);
		for (int i = 0; i < 9; i++)
		begin
			wr(rb[i][0], rb[i][1]);
			rd(rb[i][0], rb[i][2]);
		end
		for (int i = 0; i < 9; i++)
		begin
			wr(mk[i][0], mk[i][1]);
			flt[mf[i]] <= 1'b1;
			rep(1'b0, 3);
			rd(ms[i][0], ms[i][1]);
			wr(mk[i][0], mk[i][2]);
			rep(1'b1, 3);
			flt[mf[i]] <= 1'b0;
			wr(8'h78, 8'h80);
			rep(1'b0, 3);
		end
		for (int i = 0; i < 10; i++)
		begin
			wr(8'h75, lt[i][0]);
			wr(8'h76, lt[i][1]);
			flt[lf[i]] <= 1'b1;
			@(posedge i_mclk);
			flt[lf[i]] <= 1'b0;
			repeat (3) @(posedge i_mclk);
			rd(lt[i][2], lt[i][3]);
			wr(8'h78, 8'h80);
		end
		results();
	end

	// hang guard, well beyond the few hundred cycles needed
	initial
	begin
		repeat (5000) @(posedge i_mclk);
		miscompares++;
		results();
	end
endmodule // test_afrc_top
